/* File: src/ucc_cache_top.sv */
// Purpose: unified four-way write-through cache controller with monitor
// Assumes: ref_clk 100 MHz, rst synchronous active high, register port on same clock
// Notes: processor and memory ports use level request with one-cycle answer pulse
`timescale 1ns/1ps
`include "ucc_defs.svh"

// What this block does
// - reset clears every valid flag and leaves the cache disabled
// - one store for instruction and data, four ways per set
// - two kilobytes of data storage in total
// - lines are sixteen aligned bytes, filled as one block
// - all memory traffic goes out on a 32-bit master port
// - writes always go to memory; only read misses allocate
// - victim way chosen round robin per set
// - index and tag taken from the physical address unchanged
// - data seen by the processor equals what memory returns
// - control enable bit set turns cache on, cleared turns it off
// - status reports disabled; software checks it before enable or maintenance
// - invalidate-by-line clears the valid flag of given set and way unless a fill of that line ends in the same cycle
// - after line invalidation the set's pointer targets that way
// - invalidate-all bit clears every valid flag except that of a fill ending in the same cycle
// - 32-bit monitor counts cycles, data hits or instruction hits
// - monitor advances only while its enable bit is one
// - monitor clear bit zeroes the counter
// - monitor count readable at any time in monitor status
// - all registers reached on the private peripheral bus port
module ucc_cache_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// processor access port
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic cpu_instr,
	input wire logic [31:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	input wire logic [3:0] cpu_be,
	output logic cpu_ready,
	output logic [31:0] cpu_rdata,
	// memory master port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [3:0] mem_be,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// private peripheral bus register port
	input wire logic ppb_sel,
	input wire logic ppb_write,
	input wire logic [7:0] ppb_addr,
	input wire logic [31:0] ppb_wdata,
	output logic ppb_rvalid,
	output logic [31:0] ppb_rdata
);

	// ****************************************
	// address helpers
	// ****************************************
	function automatic logic [`UCC_IDX_W-1:0] line_index(input logic [31:0] a);
		line_index = a[8:4];
	endfunction

	function automatic logic [`UCC_TAG_W-1:0] line_tag(input logic [31:0] a);
		line_tag = a[31:9];
	endfunction

	function automatic logic [`UCC_WORD_W-1:0] word_sel(input logic [31:0] a);
		word_sel = a[3:2];
	endfunction

	function automatic logic [8:0] store_addr(
		input logic [`UCC_IDX_W-1:0] idx,
		input logic [`UCC_WAY_W-1:0] way,
		input logic [`UCC_WORD_W-1:0] word
	);
		store_addr = {idx, way, word};
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	logic cache_on, cache_disabled_flag;
	logic [31:0] cfg_reg;
	ucc_pkg::ucc_mon_mode_t mon_mode;
	logic mon_on, mon_event;
	logic [31:0] mon_count;
	ucc_pkg::ucc_state_t state;
	logic [31:0] req_addr;
	logic [1:0] beat;
	logic [31:0] crit_word;
	logic [`UCC_WAY_W-1:0] victim;
	logic [`UCC_WAY_W-1:0] rr_ptr [32];
	logic hit, take, lookup_hit, fill_en, fill_beat;
	logic [`UCC_WAY_W-1:0] hit_way;
	logic st_wr_en;
	logic [8:0] st_wr_addr;
	logic [31:0] st_wr_data;
	logic [3:0] st_wr_be;
	logic [31:0] st_rd_data;
	logic wr_cfg, wr_ctrl, wr_inv_all, wr_inv_line, wr_mon_cfg, wr_mon_en, wr_mon_ctrl;
	logic inv_all, inv_line;
	logic [`UCC_IDX_W-1:0] inv_index;
	logic [`UCC_WAY_W-1:0] inv_way;

	// ****************************************
	// register write decode
	// ****************************************
	assign wr_cfg = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_CFG;
	assign wr_ctrl = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_CTRL;
	assign wr_inv_all = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_INV_ALL;
	assign wr_inv_line = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_INV_LINE;
	assign wr_mon_cfg = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_MON_CFG;
	assign wr_mon_en = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_MON_EN;
	assign wr_mon_ctrl = ppb_sel && ppb_write && ppb_addr == `UCC_OFF_MON_CTRL;

	assign inv_all = wr_inv_all && ppb_wdata[`UCC_INV_ALL_BIT];
	// acts whenever written; correctness while enabled is left to software
	assign inv_line = wr_inv_line;
	assign inv_index = ppb_wdata[`UCC_INV_IDX_MSB:`UCC_INV_IDX_LSB];
	assign inv_way = ppb_wdata[`UCC_INV_WAY_MSB:`UCC_INV_WAY_LSB];

	// ****************************************
	// control and configuration
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cache_on <= 1'b0;
		end else if (wr_ctrl) begin
			cache_on <= ppb_wdata[`UCC_CTRL_ON_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_reg <= `UCC_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_reg <= ppb_wdata;
		end
	end

	// disabled is shown only once an in-flight fill has finished,
	// so line maintenance cannot race a valid flag being set
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cache_disabled_flag <= 1'b1;
		end else begin
			cache_disabled_flag <= !cache_on && state != ucc_pkg::UCC_S_FILL;
		end
	end

	// ****************************************
	// lookup and stores
	// ****************************************
	assign take = state == ucc_pkg::UCC_S_IDLE && cpu_req && !cpu_ready;
	assign lookup_hit = take && cache_on && hit;
	assign fill_beat = state == ucc_pkg::UCC_S_FILL && mem_ack;
	assign fill_en = fill_beat && beat == `UCC_LAST_BEAT;

	ucc_tag_store u_tags (
		.ref_clk(ref_clk),
		.rst(rst),
		.lk_index(line_index(cpu_addr)),
		.lk_tag(line_tag(cpu_addr)),
		.hit(hit),
		.hit_way(hit_way),
		.fill_en(fill_en),
		.fill_index(line_index(req_addr)),
		.fill_way(victim),
		.fill_tag(line_tag(req_addr)),
		.inv_all(inv_all),
		.inv_line(inv_line),
		.inv_index(inv_index),
		.inv_way(inv_way)
	);

	// write-hit update keeps the cached copy equal to memory
	always_comb begin
		st_wr_en = 1'b0;
		st_wr_addr = store_addr(line_index(req_addr), victim, beat);
		st_wr_data = mem_rdata;
		st_wr_be = 4'hF;
		if (fill_beat) begin
			st_wr_en = 1'b1;
		end else if (lookup_hit && cpu_we) begin
			st_wr_en = 1'b1;
			st_wr_addr = store_addr(line_index(cpu_addr), hit_way, word_sel(cpu_addr));
			st_wr_data = cpu_wdata;
			st_wr_be = cpu_be;
		end
	end

	ucc_data_store u_data (
		.ref_clk(ref_clk),
		.wr_en(st_wr_en),
		.wr_addr(st_wr_addr),
		.wr_data(st_wr_data),
		.wr_be(st_wr_be),
		.rd_addr(store_addr(line_index(cpu_addr), hit_way, word_sel(cpu_addr))),
		.rd_data(st_rd_data)
	);

	// ****************************************
	// replacement pointers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int s = 0; s < 32; s++)
				rr_ptr[s] <= '0;
		end else begin
			if (fill_en)
				rr_ptr[line_index(req_addr)] <= victim + 2'h1;
			// invalidation wins over a fill in the same set
			if (inv_line)
				rr_ptr[inv_index] <= inv_way;
		end
	end

	// ****************************************
	// access sequencer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ucc_pkg::UCC_S_IDLE;
			cpu_ready <= 1'b0;
			cpu_rdata <= 32'h0000_0000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
			mem_be <= 4'h0;
			req_addr <= 32'h0000_0000;
			beat <= 2'h0;
			crit_word <= 32'h0000_0000;
			victim <= '0;
		end else begin
			cpu_ready <= 1'b0;
			unique case (state)
			ucc_pkg::UCC_S_IDLE: begin
				if (take) begin
					req_addr <= cpu_addr;
					if (cpu_we) begin
						// write-through, never allocates
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= cpu_addr;
						mem_wdata <= cpu_wdata;
						mem_be <= cpu_be;
						state <= ucc_pkg::UCC_S_SINGLE;
					end else if (cache_on && hit) begin
						cpu_ready <= 1'b1;
						cpu_rdata <= st_rd_data;
					end else if (cache_on) begin
						// read miss: fetch whole aligned line from word 0
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= {cpu_addr[31:4], 4'h0};
						mem_be <= 4'hF;
						beat <= 2'h0;
						victim <= rr_ptr[line_index(cpu_addr)];
						state <= ucc_pkg::UCC_S_FILL;
					end else begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= cpu_addr;
						mem_be <= 4'hF;
						state <= ucc_pkg::UCC_S_SINGLE;
					end
				end
			end
			ucc_pkg::UCC_S_SINGLE: begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					mem_we <= 1'b0;
					cpu_ready <= 1'b1;
					cpu_rdata <= mem_rdata;
					state <= ucc_pkg::UCC_S_IDLE;
				end
			end
			ucc_pkg::UCC_S_FILL: begin
				if (mem_ack) begin
					if (beat == word_sel(req_addr))
						crit_word <= mem_rdata;
					if (beat == `UCC_LAST_BEAT) begin
						mem_req <= 1'b0;
						cpu_ready <= 1'b1;
						cpu_rdata <= (beat == word_sel(req_addr)) ? mem_rdata : crit_word;
						state <= ucc_pkg::UCC_S_IDLE;
					end else begin
						beat <= beat + 2'h1;
						mem_addr <= {req_addr[31:4], beat + 2'h1, 2'h0};
					end
				end
			end
			endcase
		end
	end

	// ****************************************
	// performance monitor
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mon_mode <= ucc_pkg::UCC_MODE_CYCLES;
		end else if (wr_mon_cfg) begin
			mon_mode <= ucc_pkg::ucc_mon_mode_t'(ppb_wdata[`UCC_MON_MODE_MSB:`UCC_MON_MODE_LSB]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mon_on <= 1'b0;
		end else if (wr_mon_en) begin
			mon_on <= ppb_wdata[`UCC_MON_ON_BIT];
		end
	end

	// code 3 counts nothing
	always_comb begin
		unique case (mon_mode)
		ucc_pkg::UCC_MODE_CYCLES: mon_event = 1'b1;
		ucc_pkg::UCC_MODE_DATA_HITS: mon_event = lookup_hit && !cpu_instr;
		ucc_pkg::UCC_MODE_INSTR_HITS: mon_event = lookup_hit && cpu_instr;
		default: mon_event = 1'b0;
		endcase
	end

	// clear beats a coincident count
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mon_count <= `UCC_MON_COUNT_RESET;
		end else if (wr_mon_ctrl && ppb_wdata[`UCC_MON_CLR_BIT]) begin
			mon_count <= `UCC_MON_COUNT_RESET;
		end else if (mon_on && mon_event) begin
			mon_count <= mon_count + 32'h0000_0001;
		end
	end

	// ****************************************
	// register read
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ppb_rvalid <= 1'b0;
			ppb_rdata <= 32'h0000_0000;
		end else begin
			ppb_rvalid <= ppb_sel && !ppb_write;
			ppb_rdata <= 32'h0000_0000;
			if (ppb_sel && !ppb_write) begin
				unique case (ppb_addr)
				`UCC_OFF_TYPE: ppb_rdata <= `UCC_TYPE_VALUE;
				`UCC_OFF_CFG: ppb_rdata <= cfg_reg;
				`UCC_OFF_STATUS: ppb_rdata <= {31'h0, cache_disabled_flag};
				`UCC_OFF_MON_CFG: ppb_rdata <= {30'h0, mon_mode};
				`UCC_OFF_MON_EN: ppb_rdata <= {31'h0, mon_on};
				`UCC_OFF_MON_STATUS: ppb_rdata <= mon_count;
				default: ppb_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

/* File: src/ucc_defs.svh */
// Purpose: offsets, field positions, reset values and geometry of the cache
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef UCC_DEFS_SVH
`define UCC_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define UCC_OFF_TYPE 8'h00
`define UCC_OFF_CFG 8'h04
`define UCC_OFF_CTRL 8'h08
`define UCC_OFF_STATUS 8'h0C
`define UCC_OFF_INV_ALL 8'h20
`define UCC_OFF_INV_LINE 8'h24
`define UCC_OFF_MON_CFG 8'h28
`define UCC_OFF_MON_EN 8'h2C
`define UCC_OFF_MON_CTRL 8'h30
`define UCC_OFF_MON_STATUS 8'h34

// ****************************************
// field positions
// ****************************************
`define UCC_CTRL_ON_BIT 0
`define UCC_STATUS_DIS_BIT 0
`define UCC_INV_ALL_BIT 0
`define UCC_INV_IDX_LSB 4
`define UCC_INV_IDX_MSB 8
`define UCC_INV_WAY_LSB 28
`define UCC_INV_WAY_MSB 29
`define UCC_MON_MODE_LSB 0
`define UCC_MON_MODE_MSB 1
`define UCC_MON_ON_BIT 0
`define UCC_MON_CLR_BIT 0

// ****************************************
// reset values
// ****************************************
// type word: arbitrary value
`define UCC_TYPE_VALUE 32'h0000_00A5
`define UCC_CFG_RESET 32'h0000_0000
`define UCC_STATUS_RESET 32'h0000_0001
`define UCC_MON_COUNT_RESET 32'h0000_0000

// ****************************************
// geometry: 2 Kbytes, 16-byte lines, 4 ways, 32 sets
// ****************************************
`define UCC_WAY_W 2
`define UCC_IDX_W 5
`define UCC_WORD_W 2
`define UCC_TAG_W 23
`define UCC_LINES 128
`define UCC_WORDS 512
`define UCC_LAST_BEAT 2'h3

`endif

/* File: src/ucc_pkg.sv */
// Purpose: shared types of the cache controller
// Assumes: nothing
// Notes: no constants here; they live in ucc_defs.svh
package ucc_pkg;

	typedef enum logic [1:0] {
		UCC_MODE_CYCLES,
		UCC_MODE_DATA_HITS,
		UCC_MODE_INSTR_HITS
	} ucc_mon_mode_t;

	typedef enum logic [1:0] {
		UCC_S_IDLE,
		UCC_S_SINGLE,
		UCC_S_FILL
	} ucc_state_t;

endpackage

/* File: src/ucc_tag_store.sv */
// Purpose: valid flags and tags of all 128 lines, with lookup
// Assumes: one clock, synchronous active-high reset
// Notes: lookup is combinational
`timescale 1ns/1ps
`include "ucc_defs.svh"

module ucc_tag_store (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// lookup
	input wire logic [`UCC_IDX_W-1:0] lk_index,
	input wire logic [`UCC_TAG_W-1:0] lk_tag,
	output logic hit,
	output logic [`UCC_WAY_W-1:0] hit_way,
	// fill
	input wire logic fill_en,
	input wire logic [`UCC_IDX_W-1:0] fill_index,
	input wire logic [`UCC_WAY_W-1:0] fill_way,
	input wire logic [`UCC_TAG_W-1:0] fill_tag,
	// maintenance
	input wire logic inv_all,
	input wire logic inv_line,
	input wire logic [`UCC_IDX_W-1:0] inv_index,
	input wire logic [`UCC_WAY_W-1:0] inv_way
);

	logic [`UCC_LINES-1:0] valid;
	logic [`UCC_TAG_W-1:0] tags [`UCC_LINES];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			valid <= '0;
		end else begin
			if (inv_all)
				valid <= '0;
			if (inv_line)
				valid[{inv_index, inv_way}] <= 1'b0;
			// a fill ending in the same cycle still sets its flag
			if (fill_en)
				valid[{fill_index, fill_way}] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (fill_en)
			tags[{fill_index, fill_way}] <= fill_tag;
	end

	// four parallel compares on the physical tag
	always_comb begin
		hit = 1'b0;
		hit_way = '0;
		for (int w = 0; w < 4; w++) begin
			if (valid[{lk_index, 2'(w)}] && tags[{lk_index, 2'(w)}] == lk_tag) begin
				hit = 1'b1;
				hit_way = 2'(w);
			end
		end
	end

endmodule

/* File: src/ucc_data_store.sv */
// Purpose: 2 Kbytes of line data as 512 words
// Assumes: one clock
// Notes: contents have no reset; valid flags guard them
`timescale 1ns/1ps
`include "ucc_defs.svh"

module ucc_data_store (
	// clock
	input wire logic ref_clk,
	// write port
	input wire logic wr_en,
	input wire logic [8:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	// read port
	input wire logic [8:0] rd_addr,
	output logic [31:0] rd_data
);

	logic [31:0] words [`UCC_WORDS];

	always_ff @(posedge ref_clk) begin
		for (int b = 0; b < 4; b++) begin
			if (wr_en && wr_be[b])
				words[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
		end
	end

	assign rd_data = words[rd_addr];

endmodule

/* File: tb/ucc_properties.sv */
// Purpose: port-level properties of the cache controller
// Assumes: one clock, rst synchronous active high
// Notes: bound to ucc_cache_top
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module ucc_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// processor port
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	input wire logic [3:0] cpu_be,
	input wire logic cpu_ready,
	// memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	input wire logic mem_ack,
	// register port
	input wire logic ppb_sel,
	input wire logic ppb_write,
	input wire logic ppb_rvalid,
	input wire logic [31:0] ppb_rdata
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_wack;
		mem_req && mem_we && mem_ack;
	endsequence
	property p_write_done;
		s_wack |=> cpu_ready && !mem_req;
	endproperty
	property p_write_fwd;
		mem_req && mem_we |-> mem_addr == cpu_addr && mem_wdata == cpu_wdata && mem_be == cpu_be;
	endproperty
	property p_read_be;
		mem_req && !mem_we |-> mem_be == 4'hF;
	endproperty
	property p_mem_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
	endproperty
	property p_read_line;
		mem_req && !mem_we |-> mem_addr[31:4] == cpu_addr[31:4];
	endproperty
	property p_ready_pulse;
		cpu_ready |=> !cpu_ready;
	endproperty
	property p_ppb_read;
		ppb_sel && !ppb_write |=> ppb_rvalid;
	endproperty
	property p_ppb_idle;
		!ppb_rvalid |-> ppb_rdata == 32'h0;
	endproperty
	a_write_done: assert property (p_write_done)
		else $error("write not completed after ack");
	a_write_fwd: assert property (p_write_fwd)
		else $error("write not forwarded as given");
	a_read_be: assert property (p_read_be)
		else $error("read without full byte enables");
	a_mem_hold: assert property (p_mem_hold)
		else $error("memory request changed before ack");
	a_read_line: assert property (p_read_line)
		else $error("read address not from processor line");
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	a_ppb_read: assert property (p_ppb_read)
		else $error("register read not answered");
	a_ppb_idle: assert property (p_ppb_idle)
		else $error("register data outside answer");
endmodule

bind ucc_cache_top ucc_properties u_props (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req),
	.cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_be(cpu_be),
	.cpu_ready(cpu_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .ppb_sel(ppb_sel),
	.ppb_write(ppb_write), .ppb_rvalid(ppb_rvalid), .ppb_rdata(ppb_rdata));

/* File: tb/ucc_mem_model.sv */
// Purpose: memory behind the master port
// Assumes: one ack per beat, delay set by the bench
// Notes: unwritten words read as address xor salt
`timescale 1ns/1ps
// ****************************************
// memory model
// ****************************************
module ucc_mem_model (
	// clock
	input wire logic ref_clk,
	// master port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// test control
	input wire logic [3:0] dly,
	input wire logic [31:0] salt,
	output int rd_cnt,
	output int wr_cnt
);
	logic [31:0] store [logic [31:0]];
	logic [31:0] word;
	logic give;
	int waited = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		rd_cnt = 0;
		wr_cnt = 0;
	end
	always @(posedge ref_clk) begin
		give = 1'b0;
		mem_ack <= 1'b0;
		// no ack in the cycle after one: the request may be ending
		if (mem_req && !mem_ack) begin
			if (waited < dly) begin
				waited <= waited + 1;
			end else begin
				waited <= 0;
				mem_ack <= 1'b1;
				word = store.exists(mem_addr) ? store[mem_addr] : mem_addr ^ salt;
				if (mem_we) begin
					for (int b = 0; b < 4; b++) begin
						if (mem_be[b]) begin
							word[8*b +: 8] = mem_wdata[8*b +: 8];
						end
					end
					store[mem_addr] = word;
					wr_cnt <= wr_cnt + 1;
				end else begin
					give = 1'b1;
					rd_cnt <= rd_cnt + 1;
				end
			end
		end
		// released data toggles so a stale word never looks valid
		mem_rdata <= give ? word : ~mem_rdata;
	end
endmodule

/* File: tb/ucc_cache_top_bench.sv */
// Purpose: self-checking bench of the cache controller
// Assumes: 100 MHz clock, reset held 10 cycles
// Notes: read rows after the first two walk set 0 to expose victim order
`timescale 1ns/1ps
`include "ucc_defs.svh"
// ****************************************
// bench top
// ****************************************
module ucc_cache_top_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cpu_req = 1'b0;
	logic cpu_we = 1'b0;
	logic cpu_instr = 1'b0;
	logic [31:0] cpu_addr = 32'h0;
	logic [31:0] cpu_wdata = 32'h0;
	logic [3:0] cpu_be = 4'hF;
	logic ppb_sel = 1'b0;
	logic ppb_write = 1'b0;
	logic [7:0] ppb_addr = 8'h0;
	logic [31:0] ppb_wdata = 32'h0;
	logic [3:0] dly = 4'h0;
	logic [31:0] salt = 32'h5A5A_0000;
	logic cpu_ready, mem_req, mem_we, mem_ack, ppb_rvalid;
	logic [31:0] cpu_rdata, mem_addr, mem_wdata, mem_rdata, ppb_rdata, got, again;
	logic [3:0] mem_be;
	int rd_cnt, wr_cnt;
	int miscompares = 0;
	int total_checks = 0;
	logic [7:0] ro_off [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h2C, 8'h34, 8'h38};
	logic [31:0] ro_exp [8] = '{`UCC_TYPE_VALUE, `UCC_CFG_RESET, 32'h0, `UCC_STATUS_RESET,
		32'h0, 32'h0, `UCC_MON_COUNT_RESET, 32'h0};
	logic [31:0] rd_addr [10] = '{32'h104, 32'h10C, 32'h200, 32'h400, 32'h600, 32'h800,
		32'h000, 32'h400, 32'h200, 32'h600};
	int rd_beats [10] = '{4, 0, 4, 4, 4, 4, 4, 0, 4, 0};

	always #5 ref_clk = ~ref_clk;

	ucc_cache_top dut (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
		.cpu_instr(cpu_instr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_be(cpu_be),
		.cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .ppb_sel(ppb_sel), .ppb_write(ppb_write), .ppb_addr(ppb_addr),
		.ppb_wdata(ppb_wdata), .ppb_rvalid(ppb_rvalid), .ppb_rdata(ppb_rdata));
	ucc_mem_model mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .dly(dly), .salt(salt), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		ppb_sel <= 1'b1;
		ppb_write <= 1'b1;
		ppb_addr <= a;
		ppb_wdata <= d;
		@(posedge ref_clk);
		ppb_sel <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		ppb_sel <= 1'b1;
		ppb_write <= 1'b0;
		ppb_addr <= a;
		@(posedge ref_clk);
		ppb_sel <= 1'b0;
		@(posedge ref_clk);
		check({31'h0, ppb_rvalid}, 32'h1);
		d = ppb_rdata;
	endtask
	// request held until the ready pulse, bounded wait
	task automatic cpu_op(input logic we, input logic ins, input logic [31:0] a,
		input logic [31:0] wd, input int nrd, input int nwr, input logic [31:0] exp);
		int r0, w0, n;
		r0 = rd_cnt;
		w0 = wr_cnt;
		@(posedge ref_clk);
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_instr <= ins;
		cpu_addr <= a;
		cpu_wdata <= wd;
		for (n = 0; n < 200 && cpu_ready !== 1'b1; n++) begin
			@(posedge ref_clk);
		end
		if (n == 200) begin
			miscompares++;
			tally_and_finish();
		end
		cpu_req <= 1'b0;
		if (!we) begin
			check(cpu_rdata, exp);
		end
		check(32'(rd_cnt - r0), 32'(nrd));
		check(32'(wr_cnt - w0), 32'(nwr));
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			reg_rd(ro_off[i], got);
			check(got, ro_exp[i]);
		end
		reg_wr(`UCC_OFF_CFG, 32'hC3C3_1234);
		reg_rd(`UCC_OFF_CFG, got);
		check(got, 32'hC3C3_1234);
		repeat (2) cpu_op(1'b0, 1'b0, 32'h100, 32'h0, 1, 0, 32'h100 ^ salt);
		reg_wr(`UCC_OFF_CTRL, 32'h1);
		reg_rd(`UCC_OFF_STATUS, got);
		check(got, 32'h0);
		for (int i = 0; i < 10; i++) begin
			cpu_op(1'b0, 1'b0, rd_addr[i], 32'h0, rd_beats[i], 0, rd_addr[i] ^ salt);
		end
		dly <= 4'h3;
		cpu_op(1'b1, 1'b0, 32'h300, 32'hDEAD_0300, 0, 1, 32'h0);
		cpu_op(1'b0, 1'b0, 32'h300, 32'h0, 4, 0, 32'hDEAD_0300);
		cpu_op(1'b1, 1'b0, 32'h104, 32'hBEEF_0104, 0, 1, 32'h0);
		cpu_op(1'b0, 1'b0, 32'h104, 32'h0, 0, 0, 32'hBEEF_0104);
		// partial write hit: only the two low byte lanes change
		cpu_be <= 4'h3;
		cpu_op(1'b1, 1'b0, 32'h104, 32'h1234_5678, 0, 1, 32'h0);
		cpu_be <= 4'hF;
		cpu_op(1'b0, 1'b0, 32'h104, 32'h0, 0, 0, 32'hBEEF_5678);
		reg_wr(`UCC_OFF_CTRL, 32'h0);
		reg_rd(`UCC_OFF_STATUS, got);
		check(got, 32'h1);
		reg_wr(`UCC_OFF_INV_LINE, 32'h1000_0000);
		reg_wr(`UCC_OFF_CTRL, 32'h1);
		cpu_op(1'b0, 1'b0, 32'h200, 32'h0, 4, 0, 32'h200 ^ salt);
		cpu_op(1'b0, 1'b0, 32'h600, 32'h0, 0, 0, 32'h600 ^ salt);
		// mode 3 counts nothing; cycle mode counts 8 edges from enable to disable
		for (int m = 0; m < 4; m++) begin
			reg_wr(`UCC_OFF_MON_CFG, 32'(m));
			reg_wr(`UCC_OFF_MON_CTRL, 32'h1);
			reg_wr(`UCC_OFF_MON_EN, 32'h1);
			cpu_op(1'b0, 1'b0, 32'h600, 32'h0, 0, 0, 32'h600 ^ salt);
			cpu_op(1'b0, 1'b1, 32'h800, 32'h0, 0, 0, 32'h800 ^ salt);
			reg_wr(`UCC_OFF_MON_EN, 32'h0);
			reg_rd(`UCC_OFF_MON_STATUS, got);
			check(got, m == 0 ? 32'h8 : (m == 3 ? 32'h0 : 32'h1));
			reg_rd(`UCC_OFF_MON_STATUS, again);
			check(again, got);
		end
		reg_wr(`UCC_OFF_MON_CTRL, 32'h1);
		reg_rd(`UCC_OFF_MON_STATUS, got);
		check(got, 32'h0);
		salt <= 32'h0F0F_0000;
		reg_wr(`UCC_OFF_INV_ALL, 32'h1);
		cpu_op(1'b0, 1'b0, 32'h600, 32'h0, 4, 0, 32'h600 ^ 32'h0F0F_0000);
		tally_and_finish();
	end
endmodule
